/* baro_pkg.sv */
// Constants for the barometer control and interrupt logic.
// Assumes a 250 MHz core clock and a serial host with its own clock.
package baro_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLOCK_HZ = 250_000_000;
  // Output rates in hundredths of a hertz
  localparam longint RATE_1_CHZ = 100;
  localparam longint RATE_7_CHZ = 700;
  localparam longint RATE_12_CHZ = 1250;
  localparam longint RATE_25_CHZ = 2500;
  localparam longint CYC_1HZ = CLOCK_HZ * 100 / RATE_1_CHZ;
  localparam longint CYC_7HZ = CLOCK_HZ * 100 / RATE_7_CHZ;
  localparam longint CYC_12HZ = CLOCK_HZ * 100 / RATE_12_CHZ;
  localparam longint CYC_25HZ = CLOCK_HZ * 100 / RATE_25_CHZ;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_REF_XL = 6'h08;
  localparam logic [5:0] ADDR_REF_L = 6'h09;
  localparam logic [5:0] ADDR_REF_H = 6'h0A;
  localparam logic [5:0] ADDR_IDENT = 6'h0F;
  localparam logic [5:0] ADDR_CONTROL_ONE = 6'h20;
  localparam logic [5:0] ADDR_CONTROL_TWO = 6'h21;
  localparam logic [5:0] ADDR_PIN_CONTROL = 6'h22;
  localparam logic [5:0] ADDR_INT_CONFIG = 6'h23;
  localparam logic [5:0] ADDR_INT_SOURCE = 6'h24;
  localparam logic [5:0] ADDR_THS_LOW = 6'h25;
  localparam logic [5:0] ADDR_THS_HIGH = 6'h26;
  localparam logic [5:0] ADDR_STATUS = 6'h27;
  localparam logic [5:0] ADDR_PRESS_XL = 6'h28;
  localparam logic [5:0] ADDR_PRESS_L = 6'h29;
  localparam logic [5:0] ADDR_PRESS_H = 6'h2A;
  localparam logic [5:0] ADDR_TEMP_L = 6'h2B;
  localparam logic [5:0] ADDR_TEMP_H = 6'h2C;
  localparam logic [5:0] ADDR_DELTA_XL = 6'h3C;
  localparam logic [5:0] ADDR_DELTA_L = 6'h3D;
  localparam logic [5:0] ADDR_DELTA_H = 6'h3E;

  // ---------------------------------------------------------------
  // Field positions, masks and reset values
  // ---------------------------------------------------------------
  localparam int POWER_BIT = 7;
  localparam int RATE_LSB = 4;
  localparam int DIFF_BIT = 3;
  localparam int HOLD_BIT = 2;
  localparam int DELTA_BIT = 1;
  localparam int WIRE_BIT = 0;
  localparam int RELOAD_BIT = 7;
  localparam int SOFT_RESET_BIT = 2;
  localparam int AUTO_ZERO_BIT = 1;
  localparam int ONE_SHOT_BIT = 0;
  localparam int POLARITY_BIT = 7;
  localparam int DRIVE_BIT = 6;
  localparam int PIN_TWO_LSB = 3;
  localparam int PIN_ONE_LSB = 0;
  localparam int LATCH_BIT = 2;
  localparam int LOW_EN_BIT = 1;
  localparam int HIGH_EN_BIT = 0;
  localparam logic [7:0] CONTROL_TWO_MASK = 8'h87;
  localparam logic [7:0] INT_CONFIG_MASK = 8'h07;
  localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
  localparam logic [7:0] PIN_CONTROL_RESET = 8'h00;
  localparam logic [7:0] INT_CONFIG_RESET = 8'h00;

  // Interrupt pin routing codes and the one-shot rate code
  localparam logic [2:0] PIN_GROUND = 3'h0;
  localparam logic [2:0] PIN_HIGH = 3'h1;
  localparam logic [2:0] PIN_LOW = 3'h2;
  localparam logic [2:0] PIN_EITHER = 3'h3;
  localparam logic [2:0] PIN_READY = 3'h4;
  localparam logic [2:0] PIN_OFF = 3'h7;
  localparam logic [2:0] RATE_ONE_SHOT = 3'h0;

endpackage

/* baro_control.sv */
// Control, acquisition pacing and interrupt logic of the barometer.
// Assumes a serial host clocking the link port and a converter that
// answers each acquire_start with one acquire_done in the core domain.
module baro_control
  import baro_pkg::*;
#(
  parameter logic [31:0] CYCLES_1HZ = 32'(CYC_1HZ),
  parameter logic [31:0] CYCLES_7HZ = 32'(CYC_7HZ),
  parameter logic [31:0] CYCLES_12HZ = 32'(CYC_12HZ),
  parameter logic [31:0] CYCLES_25HZ = 32'(CYC_25HZ),
  parameter logic [7:0] IDENT_CODE = 8'h5A  // Arbitrary value
) (
  // Core clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Serial link
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic shared_serial_in,
  output logic shared_serial_out,
  output logic shared_serial_oe,
  output logic serial_out_pin,
  output logic serial_out_oe,
  // Interrupt pads
  output logic irq_pin_one_out,
  output logic irq_pin_one_oe,
  output logic irq_pin_two_out,
  output logic irq_pin_two_oe,
  // Converter side
  output logic power_active,
  output logic acquire_start,
  input wire logic acquire_done,
  input wire logic [23:0] raw_pressure,
  input wire logic [15:0] raw_temperature,
  output logic trim_reload
);

  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl1, ctrl2, ctrl3, int_cfg;
    logic [15:0] ths;
    logic [23:0] ref_p, delta;
    logic [2:0] src;
    logic p_da, t_da, p_or, t_or;
    logic [23:0] new_p, out_p;
    logic [15:0] new_t, out_t;
    logic p_lo, p_hi, t_lo, t_hi;
    logic [31:0] p_cnt, t_cnt, boot_cnt;
    logic t_due, busy, busy_t, az_done, high_c, low_c;
    logic start, reload;
    logic pin1_out, pin1_oe, pin2_out, pin2_oe;
    logic cs_s1, cs_s2, wr_s1, wr_s2, wr_s3, rd_s1, rd_s2, rd_s3;
    logic [63:0][7:0] snap;
  } core_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sh;
    logic hdr, rd, inc;
  } frame_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] obuf;
    logic wr_tog;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_tog;
    logic [5:0] rd_addr;
  } link_t;

  core_t q, n;
  frame_t fq, fn;
  link_t lq, ln;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Pressure period for a rate code; one-shot falls back to 1 Hz
  function automatic logic [31:0] p_period(input logic [2:0] sel);
    unique case (sel)
      3'h2, 3'h5: p_period = CYCLES_7HZ;
      3'h3, 3'h6: p_period = CYCLES_12HZ;
      3'h4, 3'h7: p_period = CYCLES_25HZ;
      default: p_period = CYCLES_1HZ;
    endcase
  endfunction

  // Temperature runs at 1 Hz except in the matched-rate codes
  function automatic logic [31:0] t_period(input logic [2:0] sel);
    t_period = sel[2] && sel[1:0] != 2'h0 ? p_period(sel) : CYCLES_1HZ;
  endfunction

  // Pad value and enable for one interrupt pin
  function automatic logic [1:0] pad(input logic [2:0] sel,
      input logic hi, input logic lo, input logic rdy,
      input logic low_act, input logic od);
    logic act;
    logic lvl;
    act = 1'b0;
    unique case (sel)
      PIN_HIGH: act = hi;
      PIN_LOW: act = lo;
      PIN_EITHER: act = hi | lo;
      PIN_READY: act = rdy;
      default: act = 1'b0;
    endcase
    lvl = act ^ low_act;
    if (sel == PIN_OFF) begin
      pad = 2'b00;
    end else if (sel == PIN_GROUND || sel[2:1] == 2'b10 && sel[0] ||
        sel == 3'h6) begin
      pad = 2'b01;  // Reserved codes also pull low
    end else if (od) begin
      pad = {1'b0, ~lvl};  // Open drain only ever sinks
    end else begin
      pad = {lvl, 1'b1};
    end
  endfunction

  // Read value of one register address
  function automatic logic [7:0] reg_value(input core_t s,
      input logic [5:0] a);
    unique case (a)
      ADDR_REF_XL: reg_value = s.ref_p[7:0];
      ADDR_REF_L: reg_value = s.ref_p[15:8];
      ADDR_REF_H: reg_value = s.ref_p[23:16];
      ADDR_IDENT: reg_value = IDENT_CODE;
      ADDR_CONTROL_ONE: reg_value = s.ctrl1;
      ADDR_CONTROL_TWO: reg_value = s.ctrl2;
      ADDR_PIN_CONTROL: reg_value = s.ctrl3;
      ADDR_INT_CONFIG: reg_value = s.int_cfg;
      ADDR_INT_SOURCE: reg_value = {5'h00, s.src};
      ADDR_THS_LOW: reg_value = s.ths[7:0];
      ADDR_THS_HIGH: reg_value = s.ths[15:8];
      ADDR_STATUS:
        reg_value = {2'h0, s.p_or, s.t_or, 2'h0, s.p_da, s.t_da};
      ADDR_PRESS_XL: reg_value = s.out_p[7:0];
      ADDR_PRESS_L: reg_value = s.out_p[15:8];
      ADDR_PRESS_H: reg_value = s.out_p[23:16];
      ADDR_TEMP_L: reg_value = s.out_t[7:0];
      ADDR_TEMP_H: reg_value = s.out_t[15:8];
      ADDR_DELTA_XL: reg_value = s.delta[7:0];
      ADDR_DELTA_L: reg_value = s.delta[15:8];
      ADDR_DELTA_H: reg_value = s.delta[23:16];
      default: reg_value = 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Serial link domain
  // ---------------------------------------------------------------
  logic frame_rst_n;
  logic [7:0] byte_in;
  logic [5:0] next_addr;
  logic rd_active;
  logic wire_three;

  // Frame counters restart whenever select is released
  assign frame_rst_n = arst_n & ~chip_select_n;
  assign byte_in = {fq.sh, shared_serial_in};
  assign next_addr = lq.addr + {5'h00, fq.inc};

  // Header byte: read flag, increment flag, six-bit address
  always_comb begin
    fn = fq;
    ln = lq;
    fn.cnt = fq.cnt + 3'h1;
    fn.sh = {fq.sh[5:0], shared_serial_in};
    ln.obuf = {lq.obuf[6:0], 1'b0};
    if (fq.cnt == 3'h7) begin
      if (!fq.hdr) begin
        fn.hdr = 1'b1;
        fn.rd = byte_in[7];
        fn.inc = byte_in[6];
        ln.addr = byte_in[5:0];
        if (byte_in[7]) begin
          ln.obuf = q.snap[byte_in[5:0]];
        end
      end else if (fq.rd) begin
        // Side effects only for a byte fully shifted out, not a prefetch
        ln.rd_tog = ~lq.rd_tog;
        ln.rd_addr = lq.addr;
        ln.addr = next_addr;
        ln.obuf = q.snap[next_addr];
      end else begin
        ln.wr_addr = lq.addr;
        ln.wr_data = byte_in;
        ln.wr_tog = ~lq.wr_tog;
        ln.addr = next_addr;
      end
    end
  end

  // Toggles survive frame ends so the core never sees a false event
  always_ff @(posedge serial_clock or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fq <= '0;
    end else begin
      fq <= fn;
    end
  end

  always_ff @(posedge serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      lq <= '0;
    end else begin
      lq <= ln;
    end
  end

  // Snapshot is frozen while selected, so reading it here is safe
  assign wire_three = q.snap[ADDR_CONTROL_ONE][WIRE_BIT];
  assign rd_active = ~chip_select_n & fq.hdr & fq.rd;
  assign serial_out_pin = lq.obuf[7];
  assign serial_out_oe = rd_active & ~wire_three;
  assign shared_serial_out = lq.obuf[7];
  assign shared_serial_oe = rd_active & wire_three;

  // ---------------------------------------------------------------
  // Core domain
  // ---------------------------------------------------------------
  logic wr_ev, rd_ev, hold_p, hold_t, done, differential_enable;
  logic hi_ev, lo_ev;
  logic [2:0] sel;
  logic [23:0] comp, diff, p_val;
  logic [1:0] pad1, pad2;

  assign wr_ev = q.wr_s2 ^ q.wr_s3;
  assign rd_ev = q.rd_s2 ^ q.rd_s3;
  assign sel = q.ctrl1[RATE_LSB +: 3];
  assign differential_enable = q.ctrl1[DIFF_BIT];
  assign done = q.busy & acquire_done;
  // Delta correction and reference difference
  assign comp = raw_pressure + (q.ctrl1[DELTA_BIT] ? q.delta : 24'h0);
  assign diff = comp - q.ref_p;
  assign hold_p = q.ctrl1[HOLD_BIT] & (q.p_lo | q.p_hi);
  assign hold_t = q.ctrl1[HOLD_BIT] & (q.t_lo | q.t_hi);
  assign hi_ev = done & differential_enable & q.int_cfg[HIGH_EN_BIT] &
      ($signed(diff) > $signed({8'h00, q.ths}));
  assign lo_ev = done & differential_enable & q.int_cfg[LOW_EN_BIT] &
      ($signed(diff) < -$signed({8'h00, q.ths}));
  assign pad1 = pad(q.ctrl3[PIN_ONE_LSB +: 3], q.high_c, q.low_c, q.p_da,
      q.ctrl3[POLARITY_BIT], q.ctrl3[DRIVE_BIT]);
  assign pad2 = pad(q.ctrl3[PIN_TWO_LSB +: 3], q.high_c, q.low_c, q.p_da,
      q.ctrl3[POLARITY_BIT], q.ctrl3[DRIVE_BIT]);

  // Next core state; order gives hardware sets priority over read clears, and soft reset priority over both
  always_comb begin
    n = q;
    p_val = diff;
    n.cs_s1 = chip_select_n;
    n.cs_s2 = q.cs_s1;
    n.wr_s1 = lq.wr_tog;
    n.wr_s2 = q.wr_s1;
    n.wr_s3 = q.wr_s2;
    n.rd_s1 = lq.rd_tog;
    n.rd_s2 = q.rd_s1;
    n.rd_s3 = q.rd_s2;
    n.start = 1'b0;
    n.reload = 1'b0;
    // Host writes; reserved bits are masked off
    if (wr_ev) begin
      unique case (lq.wr_addr)
        ADDR_CONTROL_ONE: n.ctrl1 = lq.wr_data;
        ADDR_CONTROL_TWO: n.ctrl2 = lq.wr_data & CONTROL_TWO_MASK;
        ADDR_PIN_CONTROL: n.ctrl3 = lq.wr_data;
        ADDR_INT_CONFIG: n.int_cfg = lq.wr_data & INT_CONFIG_MASK;
        ADDR_THS_LOW: n.ths[7:0] = lq.wr_data;
        ADDR_THS_HIGH: n.ths[15:8] = lq.wr_data;
        ADDR_REF_XL: n.ref_p[7:0] = lq.wr_data;
        ADDR_REF_L: n.ref_p[15:8] = lq.wr_data;
        ADDR_REF_H: n.ref_p[23:16] = lq.wr_data;
        ADDR_DELTA_XL: n.delta[7:0] = lq.wr_data;
        ADDR_DELTA_L: n.delta[15:8] = lq.wr_data;
        ADDR_DELTA_H: n.delta[23:16] = lq.wr_data;
        default: n.ctrl1 = q.ctrl1;
      endcase
    end
    // Read side effects: flag clears and block-update tracking
    if (rd_ev) begin
      unique case (lq.rd_addr)
        ADDR_INT_SOURCE: n.src = q.int_cfg[LATCH_BIT] ? 3'h0 : q.src;
        ADDR_PRESS_XL, ADDR_PRESS_L: n.p_lo = 1'b1;
        ADDR_PRESS_H: {n.p_hi, n.p_da, n.p_or} = 3'b100;
        ADDR_TEMP_L: n.t_lo = 1'b1;
        ADDR_TEMP_H: {n.t_hi, n.t_da, n.t_or} = 3'b100;
        default: n.src = n.src;
      endcase
    end
    // Output hold releases once both halves have been read
    if (!q.ctrl1[HOLD_BIT] || n.p_lo && n.p_hi) {n.p_lo, n.p_hi} = 2'b00;
    if (!q.ctrl1[HOLD_BIT] || n.t_lo && n.t_hi) {n.t_lo, n.t_hi} = 2'b00;
    n.out_p = hold_p ? q.out_p : q.new_p;
    n.out_t = hold_t ? q.out_t : q.new_t;
    // Rate timers run only while powered in a periodic mode
    if (q.ctrl1[POWER_BIT] && sel != RATE_ONE_SHOT) begin
      n.p_cnt = q.p_cnt + 32'h1;
      n.t_cnt = q.t_cnt + 32'h1;
      if (q.t_cnt >= t_period(sel) - 32'h1) begin
        n.t_cnt = 32'h0;
        n.t_due = 1'b1;
      end
      if (q.p_cnt >= p_period(sel) - 32'h1) begin
        n.p_cnt = 32'h0;
        if (!q.busy) begin
          n.start = 1'b1;
          n.busy = 1'b1;
          n.busy_t = n.t_due;
          n.t_due = 1'b0;
        end
      end
    end else begin
      n.p_cnt = 32'h0;
      n.t_cnt = 32'h0;
      n.t_due = 1'b0;
    end
    // One-shot acquisition of both quantities
    if (q.ctrl2[ONE_SHOT_BIT] && sel == RATE_ONE_SHOT && !q.busy) begin
      n.start = 1'b1;
      n.busy = 1'b1;
      n.busy_t = 1'b1;
    end
    // Conversion result; auto-zero captures the reference once
    if (!q.ctrl2[AUTO_ZERO_BIT]) n.az_done = 1'b0;
    if (done) begin
      n.busy = 1'b0;
      if (q.ctrl2[AUTO_ZERO_BIT] && !q.az_done) begin
        n.ref_p = comp;
        n.az_done = 1'b1;
        p_val = 24'h0;
      end
      n.new_p = q.ctrl2[AUTO_ZERO_BIT] ? p_val : comp;
      n.p_or = n.p_or | n.p_da;
      n.p_da = 1'b1;
      n.high_c = hi_ev;
      n.low_c = lo_ev;
      if (q.busy_t) begin
        n.new_t = raw_temperature;
        n.t_or = n.t_or | n.t_da;
        n.t_da = 1'b1;
      end
      if (sel == RATE_ONE_SHOT) n.ctrl2[ONE_SHOT_BIT] = 1'b0;
    end
    // Interrupt source: sticky when latched, else follows condition
    if (!differential_enable) begin
      n.high_c = 1'b0;
      n.low_c = 1'b0;
      n.src = 3'h0;
    end else if (q.int_cfg[LATCH_BIT]) begin
      n.src[1:0] = n.src[1:0] | {lo_ev, hi_ev};
    end else begin
      n.src[1:0] = {n.low_c, n.high_c};
    end
    n.src[2] = |n.src[1:0];
    // Trim reload waits one output-rate period
    if (q.ctrl2[RELOAD_BIT]) begin
      n.boot_cnt = q.boot_cnt + 32'h1;
      if (q.boot_cnt >= p_period(sel) - 32'h1) begin
        n.boot_cnt = 32'h0;
        n.reload = 1'b1;
        n.ctrl2[RELOAD_BIT] = 1'b0;
        if (q.ctrl2[SOFT_RESET_BIT]) begin
          n.ctrl1 = CONTROL_ONE_RESET;
          n.ctrl2 = CONTROL_TWO_RESET;
          n.ctrl3 = PIN_CONTROL_RESET;
          n.int_cfg = INT_CONFIG_RESET;
          n.ths = 16'h0000;
          n.ref_p = 24'h000000;
          n.delta = 24'h000000;
          n.src = 3'h0;
          {n.p_da, n.t_da, n.p_or, n.t_or} = 4'h0;
        end
      end
    end else begin
      n.boot_cnt = 32'h0;
    end
    // Pads are registered from the current configuration
    {n.pin1_out, n.pin1_oe} = pad1;
    {n.pin2_out, n.pin2_oe} = pad2;
    // Snapshot refreshes only while the link is idle
    if (q.cs_s2) begin
      for (int i = 0; i < 64; i++) begin
        n.snap[i] = reg_value(q, 6'(i));
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign power_active = q.ctrl1[POWER_BIT];
  assign acquire_start = q.start;
  assign trim_reload = q.reload;
  assign irq_pin_one_out = q.pin1_out;
  assign irq_pin_one_oe = q.pin1_oe;
  assign irq_pin_two_out = q.pin2_out;
  assign irq_pin_two_oe = q.pin2_oe;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  power_gate_a: assert property (
    (q.start && $past(sel) != RATE_ONE_SHOT) |-> $past(q.ctrl1[POWER_BIT]))
    else $error("periodic start while powered down");
  rate_period_a: assert property (
    (q.ctrl1[POWER_BIT] && sel != RATE_ONE_SHOT && $stable(q.ctrl1) &&
     q.p_cnt == p_period(sel) - 32'h1 && !q.busy) |=> q.start)
    else $error("rate timer did not start acquisition");
  diff_off_a: assert property (
    !q.ctrl1[DIFF_BIT] |=> q.src == 3'h0 && !q.high_c && !q.low_c)
    else $error("interrupt state while differential disabled");
  hold_out_a: assert property (
    (q.ctrl1[HOLD_BIT] && q.p_lo && !q.p_hi) |=> $stable(q.out_p))
    else $error("pressure output changed while held");
  one_shot_a: assert property (
    (done && sel == RATE_ONE_SHOT && q.ctrl2[ONE_SHOT_BIT] &&
     !q.ctrl2[SOFT_RESET_BIT])
    |=> !q.ctrl2[ONE_SHOT_BIT] && q.p_da && q.t_da)
    else $error("one-shot did not complete cleanly");
  reload_wait_a: assert property (
    q.reload |-> $past(q.boot_cnt) == p_period($past(sel)) - 32'h1 ||
    $past(q.boot_cnt) >= p_period($past(sel)) - 32'h1)
    else $error("trim reload fired early");
  reload_clear_a: assert property (
    q.reload |-> !q.ctrl2[RELOAD_BIT] && $past(q.ctrl2[RELOAD_BIT]))
    else $error("trim reload bit not cleared");
  pin_off_a: assert property (
    (q.ctrl3[2:0] == PIN_OFF) |=> !q.pin1_oe)
    else $error("pin one driven while off");
  ready_pad_a: assert property (
    (q.ctrl3[2:0] == PIN_READY && !q.ctrl3[DRIVE_BIT] && $stable(q.ctrl3))
    |=> q.pin1_oe &&
    q.pin1_out == ($past(q.p_da) ^ $past(q.ctrl3[POLARITY_BIT])))
    else $error("data ready pad level wrong");
  latch_keep_a: assert property (
    (q.int_cfg[LATCH_BIT] && q.src[0] && differential_enable && !rd_ev &&
     !q.ctrl2[SOFT_RESET_BIT] && !wr_ev) |=> q.src[0] && q.src[2])
    else $error("latched high flag lost");
  ready_set_a: assert property (
    (done && !q.ctrl2[SOFT_RESET_BIT]) |=> q.p_da)
    else $error("ready flag not set by sample");

endmodule

/* baro_host.sv */
// Serial host model: one header byte and one data byte per frame.
// Assumes the device samples on the rising link clock edge.
module baro_host (
  // Link lines
  output logic sck,
  output logic cs_n,
  output logic sdi,
  // Read data and mode
  input logic so4,
  input logic oe4,
  input logic so3,
  input logic oe3,
  input logic three
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Frame driver
  // --------------------------------------------------------------
  initial begin
    sck = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Link clock parked high between frames, period 30 ns
  task automatic xfer(input logic rd, input logic [5:0] a,
                      input logic [7:0] wd, output logic [7:0] q);
    logic [15:0] sh;
    logic last;
    last = 1'b0;
    sh = {rd, 1'b0, a, wd};
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #15 sck = 1'b0;
      sdi = sh[i];
      // An undriven pin shows the inverse of its last bit
      #15 if (i < 8) begin
        last = three ? (oe3 ? so3 : ~last) : (oe4 ? so4 : ~last);
        q[i] = last;
      end
      sck = 1'b1;
    end
    #15 cs_n = 1'b1;
    sdi = ~sdi;
    #60;
  endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the barometer control block.
// Assumes a converter that answers each start on the next cycle.
module tb_top import baro_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic sck, cs_n, sdi, so3, oe3, so4, oe4, o1, e1, o2, e2, pwr, start;
  logic done = 1'b0;
  logic trim;
  logic saw_trim = 1'b0;
  logic three = 1'b0;
  logic [23:0] raw_p = 24'h123456;
  logic [15:0] raw_t = 16'h0ABC;
  logic [7:0] q;
  logic [7:0] pins [7] = '{8'h00, 8'h04, 8'h84, 8'hC4, 8'h44, 8'h07, 8'h27};
  logic [3:0] pexp [7] = '{4'h5, 4'hD, 4'h5, 4'h5, 4'h1, 4'h1, 4'h3};
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int gap = 0;
  int last_start = 0;
  always #2 clock = ~clock;
  baro_control #(.CYCLES_1HZ(200), .CYCLES_7HZ(150), .CYCLES_12HZ(120),
    .CYCLES_25HZ(100)) i_dut (.clock(clock), .arst_n(arst_n),
    .serial_clock(sck), .chip_select_n(cs_n), .shared_serial_in(sdi),
    .shared_serial_out(so3), .shared_serial_oe(oe3),
    .serial_out_pin(so4), .serial_out_oe(oe4),
    .irq_pin_one_out(o1), .irq_pin_one_oe(e1), .irq_pin_two_out(o2),
    .irq_pin_two_oe(e2), .power_active(pwr), .acquire_start(start),
    .acquire_done(done), .raw_pressure(raw_p), .raw_temperature(raw_t),
    .trim_reload(trim));
  baro_host i_host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .so4(so4),
    .oe4(oe4), .so3(so3), .oe3(oe3), .three(three));
  // --------------------------------------------------------------
  // Converter stand-in and hang guard
  // --------------------------------------------------------------
  always @(posedge clock) begin
    done <= start;
    cyc <= cyc + 1;
    if (trim)
      saw_trim <= 1'b1;
    // Spacing of acquisition starts shows the rate timer
    if (start) begin
      gap <= cyc - last_start;
      last_start <= cyc;
    end
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    i_host.xfer(1'b1, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_host.xfer(1'b0, a, d, q);
  endtask
  task automatic close_out;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // --------------------------------------------------------------
  // Main sequence; rate changes only while powered down
  // --------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    for (int a = 32; a < 36; a++)
      rd(6'(a), 8'h00);
    wr(ADDR_INT_CONFIG, 8'hFF);
    rd(ADDR_INT_CONFIG, 8'h07);
    wr(ADDR_CONTROL_TWO, 8'h78);
    rd(ADDR_CONTROL_TWO, 8'h00);
    wr(ADDR_CONTROL_ONE, 8'h80);
    chk("power", 8'h01, {7'h0, pwr});
    wr(ADDR_CONTROL_ONE, 8'h00);
    wr(ADDR_CONTROL_TWO, 8'h01);
    repeat (20) @(posedge clock);
    rd(ADDR_CONTROL_TWO, 8'h00);
    rd(ADDR_STATUS, 8'h03);
    rd(ADDR_INT_SOURCE, 8'h00);
    // Ready flag stays up through the pad table
    foreach (pins[i]) begin
      wr(ADDR_PIN_CONTROL, pins[i]);
      chk("pads", {4'h0, pexp[i]}, {4'h0, o1, e1, o2, e2});
    end
    rd(ADDR_PRESS_XL, 8'h56);
    rd(ADDR_PRESS_L, 8'h34);
    rd(ADDR_PRESS_H, 8'h12);
    rd(ADDR_STATUS, 8'h01);
    // Threshold first, then the differential logic
    wr(ADDR_THS_LOW, 8'h10);
    wr(ADDR_INT_CONFIG, 8'h05);
    wr(ADDR_CONTROL_ONE, 8'h08);
    wr(ADDR_CONTROL_TWO, 8'h01);
    repeat (20) @(posedge clock);
    rd(ADDR_INT_SOURCE, 8'h05);
    rd(ADDR_INT_SOURCE, 8'h00);
    wr(ADDR_CONTROL_TWO, 8'h80);
    chk("trim early", 8'h00, {7'h0, saw_trim});
    repeat (260) @(posedge clock);
    chk("trim", 8'h01, {7'h0, saw_trim});
    rd(ADDR_CONTROL_TWO, 8'h00);
    // Periodic pacing at 1 Hz
    wr(ADDR_CONTROL_ONE, 8'h10);
    wr(ADDR_CONTROL_ONE, 8'h90);
    repeat (500) @(posedge clock);
    chk("period", 8'hC8, gap > 255 ? 8'hFF : 8'(gap));
    wr(ADDR_CONTROL_ONE, 8'h10);
    // Block update keeps the old high byte across a new sample
    wr(ADDR_CONTROL_ONE, 8'h04);
    rd(ADDR_PRESS_XL, 8'h56);
    @(posedge clock);
    raw_p <= 24'h0FEDCB;
    wr(ADDR_CONTROL_TWO, 8'h01);
    repeat (20) @(posedge clock);
    rd(ADDR_PRESS_H, 8'h12);
    rd(ADDR_PRESS_XL, 8'hCB);
    // Delta offset, then auto-zero and an unlatched low event
    wr(ADDR_CONTROL_ONE, 8'h02);
    wr(ADDR_DELTA_XL, 8'h05);
    wr(ADDR_CONTROL_TWO, 8'h01);
    repeat (20) @(posedge clock);
    rd(ADDR_PRESS_XL, 8'hD0);
    wr(ADDR_CONTROL_TWO, 8'h03);
    repeat (20) @(posedge clock);
    rd(ADDR_REF_XL, 8'hD0);
    rd(ADDR_PRESS_H, 8'h00);
    wr(ADDR_INT_CONFIG, 8'h02);
    wr(ADDR_CONTROL_ONE, 8'h0A);
    @(posedge clock);
    raw_p <= 24'h0FED00;
    wr(ADDR_CONTROL_TWO, 8'h03);
    repeat (20) @(posedge clock);
    rd(ADDR_PRESS_XL, 8'h35);
    rd(ADDR_INT_SOURCE, 8'h06);
    rd(ADDR_INT_SOURCE, 8'h06);
    // Soft reset together with trim reload restores defaults
    wr(ADDR_CONTROL_TWO, 8'h84);
    repeat (260) @(posedge clock);
    rd(ADDR_INT_CONFIG, 8'h00);
    rd(ADDR_THS_LOW, 8'h00);
    wr(ADDR_CONTROL_ONE, 8'h01);
    three = 1'b1;
    rd(ADDR_CONTROL_ONE, 8'h01);
    close_out();
  end
endmodule
